// ===== rtl/pfc_pkg.sv
// Package for the parallel flash host controller.
// Assumes a 100 MHz mclk_i; all pin timing counts derive from it.
package pfc_pkg;
  localparam int  CLK_NS           = 10;
  localparam int  WR_PULSE_NS      = 50;
  localparam int  WR_PULSE_CYC     = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int  RD_ACCESS_NS     = 150;
  localparam int  RD_ACCESS_CYC    = (RD_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int  RST_WAIT_US      = 5;
  localparam int  RST_WAIT_CYC     = (RST_WAIT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int  SUSP_MAX_US      = 15;
  localparam int  SUSP_MAX_CYC     = (SUSP_MAX_US * 1000) / CLK_NS;
  localparam int  CNT_W            = 16;
  localparam int  ADDR_W           = 19;
  localparam int  DATA_W           = 8;
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 19'h05555;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 19'h02AAA;
  localparam logic [ADDR_W-1:0] SETUP_ADDR   = 19'h05555;
  localparam logic [ADDR_W-1:0] PROT_ADDR    = 19'h00002;
  localparam logic [DATA_W-1:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [DATA_W-1:0] UNLOCK2_DATA = 8'h55;
  localparam logic [DATA_W-1:0] CMD_SETUP_ER = 8'h80;
  localparam logic [DATA_W-1:0] CMD_CHIP_ER  = 8'h10;
  localparam logic [DATA_W-1:0] CMD_SECT_ER  = 8'h30;
  localparam logic [DATA_W-1:0] CMD_PROGRAM  = 8'hA0;
  localparam logic [DATA_W-1:0] CMD_SIGNAT   = 8'h90;
  localparam logic [DATA_W-1:0] CMD_PAUSE    = 8'hB0;
  localparam logic [DATA_W-1:0] CMD_RESET    = 8'hF0;
  localparam int  BLK_LSB          = 16;
  localparam int  POLL_BIT         = 7;
  localparam int  ALT_BIT          = 6;
  localparam int  FAIL_BIT         = 5;
  localparam int  ACCUM_BIT        = 3;
  // Operation codes presented at op_i
  typedef enum logic [2:0] {
    PFC_OP_READ    = 3'h0,
    PFC_OP_PROGRAM = 3'h1,
    PFC_OP_CHIP_ER = 3'h2,
    PFC_OP_SECT_ER = 3'h3,
    PFC_OP_ADD_BLK = 3'h4,
    PFC_OP_PAUSE   = 3'h5,
    PFC_OP_RESUME  = 3'h6,
    PFC_OP_PROT_RD = 3'h7
  } pfc_op_e;
  localparam logic [2:0] PFC_OP_RESET_SEL = 3'h0;
endpackage : pfc_pkg

// ===== rtl/pfc_bus_cycle.sv
// Single bus cycle engine: one write or one read on the flash pins.
// Assumes pins run in the mclk_i domain; read data is synchronised here.
`timescale 1ns/10ps
module pfc_bus_cycle
  import pfc_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic              start_i,
  input  wire logic              write_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output logic                   done_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic [ADDR_W-1:0]      fl_addr_o,
  output logic                   fl_ce_n_o,
  output logic                   fl_oe_n_o,
  output logic                   fl_we_n_o,
  output logic [DATA_W-1:0]      fl_dq_o,
  output logic                   fl_dq_oe_o,
  input  wire logic [DATA_W-1:0] fl_dq_i
);
  typedef enum logic [1:0] {
    PFC_BC_IDLE = 2'b00,
    PFC_BC_ACT  = 2'b01,
    PFC_BC_HOLD = 2'b10
  } pfc_bc_e;
  pfc_bc_e           st_r,   st_nxt;
  logic [CNT_W-1:0]  cnt_r,  cnt_nxt;
  logic              wr_r,   wr_nxt;
  logic [ADDR_W-1:0] a_r,    a_nxt;
  logic [DATA_W-1:0] d_r,    d_nxt;
  logic [DATA_W-1:0] rd_r,   rd_nxt;
  logic [DATA_W-1:0] sync1_r, sync2_r;
  // Two flops on the pin data before anything reads it
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end else begin
      sync1_r <= fl_dq_i;
      sync2_r <= sync1_r;
    end
  end
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    wr_nxt  = wr_r;
    a_nxt   = a_r;
    d_nxt   = d_r;
    rd_nxt  = rd_r;
    done_o  = 1'b0;
    case (st_r)
      PFC_BC_IDLE: begin
        if (start_i) begin
          st_nxt  = PFC_BC_ACT;
          wr_nxt  = write_i;
          a_nxt   = addr_i;
          d_nxt   = wdata_i;
          // Read waits for access time plus the two sync flops
          cnt_nxt = write_i ? CNT_W'(WR_PULSE_CYC) : CNT_W'(RD_ACCESS_CYC + 2);
        end
      end
      PFC_BC_ACT: begin
        if (cnt_r == '0) begin
          st_nxt = PFC_BC_HOLD;
          if (!wr_r) rd_nxt = sync2_r;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: begin
        // Enables released one cycle; gives the recovery gap
        done_o = 1'b1;
        st_nxt = PFC_BC_IDLE;
      end
    endcase
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r  <= PFC_BC_IDLE;
      cnt_r <= '0;
      wr_r  <= 1'b0;
      a_r   <= '0;
      d_r   <= '0;
      rd_r  <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_r  <= wr_nxt;
      a_r   <= a_nxt;
      d_r   <= d_nxt;
      rd_r  <= rd_nxt;
    end
  end
  // Address held steady over the whole cycle, latched at the falling enable
  assign fl_addr_o  = a_r;
  assign fl_ce_n_o  = (st_r != PFC_BC_ACT);
  assign fl_we_n_o  = !((st_r == PFC_BC_ACT) && wr_r);
  assign fl_oe_n_o  = !((st_r == PFC_BC_ACT) && !wr_r);
  assign fl_dq_o    = d_r;
  assign fl_dq_oe_o = wr_r && (st_r != PFC_BC_IDLE);
  assign rdata_o    = rd_r;
endmodule : pfc_bus_cycle

// ===== rtl/pfc_ctrl.sv
// Host controller for a byte-wide parallel flash: issues command sequences.
// Assumes one outstanding request at a time; user polls busy via ready_o.
//
// Summary of operation
// [RULE1] Protection read returns 01h for a protected block, 00h otherwise.
// [RULE2] Host never uses protection read to verify during block protection.
// [RULE3] Chip erase: unlock, 80h at 5555h, unlock, 10h at 5555h.
// [RULE4] A bad unlock or confirm makes the device drop to read array.
// [RULE5] Device preprograms to 00h itself; host issues no preprogram.
// [RULE6] After sixth write, reads return status until the operation ends.
// [RULE7] During chip erase only reset is accepted.
// [RULE8] Poll bit 0 then 1, toggle bit alternates, failure bit flags error.
// [RULE9] Block erase: unlock, 80h, unlock, 30h with block address.
// [RULE10] Extra 30h writes add blocks and restart the roughly 100us timeout.
// [RULE11] Accumulation timer bit 0 while timeout runs, 1 once erasing.
// [RULE12] Any command other than 30h during timeout cancels block erase; the flash model pauses the erase on B0h instead.
// [RULE13] During block erase only pause and reset are accepted.
// [RULE14] After an erase error the host writes reset to idle the device.
// [RULE15] Byte program: unlock, A0h, then address and data write.
// [RULE16] During program all commands ignored; reads return status bits.
// [RULE17] Programming only clears bits; it never sets a zero to one.
// [RULE18] Single B0h at any address pauses a running block erase.
// [RULE19] Toggle stops 0.1us to 15us after pause, then read array.
// [RULE20] Host checks pause by toggle reads outside erased blocks.
// [RULE21] While paused only continue and reset are accepted.
// [RULE22] 30h at any address with no unlock continues the erase.
// [RULE23] Unlock is AAh to 5555h, then 55h to 2AAAh.
// [RULE24] F0h returns read array; wait 5us if it interrupted an erase.
// [RULE25] Signature mode: unlock then 90h to 5555h.
// [RULE26] Device starts in read array; no writes below lockout level.
// [RULE27] In read array mode a read returns the stored byte.
`timescale 1ns/10ps
module pfc_ctrl
  import pfc_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic              req_i,
  input  wire logic [2:0]        op_i,
  input  wire logic              reset_cmd_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic [DATA_W-1:0] safe_addr_hi_i,
  output logic                   ready_o,
  output logic                   done_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic                   fail_o,
  output logic                   bits_dropped_o,
  output logic [ADDR_W-1:0]      fl_addr_o,
  output logic                   fl_ce_n_o,
  output logic                   fl_oe_n_o,
  output logic                   fl_we_n_o,
  output logic [DATA_W-1:0]      fl_dq_o,
  output logic                   fl_dq_oe_o,
  input  wire logic [DATA_W-1:0] fl_dq_i
);
  typedef enum logic [3:0] {
    PFC_IDLE   = 4'b0000,
    PFC_SEQ    = 4'b0001,
    PFC_POLL1  = 4'b0010,
    PFC_POLL2  = 4'b0011,
    PFC_WAIT   = 4'b0100,
    PFC_FINISH = 4'b0101,
    PFC_ERRRST = 4'b0110,
    PFC_SUSPW  = 4'b0111
  } pfc_st_e;
  pfc_st_e           st_r,   st_nxt;
  logic [2:0]        idx_r,  idx_nxt;
  logic [2:0]        len_r,  len_nxt;
  logic [2:0]        op_r,   op_nxt;
  logic              rst_r,  rst_nxt;
  logic [ADDR_W-1:0] a_r,    a_nxt;
  logic [DATA_W-1:0] d_r,    d_nxt;
  logic [DATA_W-1:0] tog_r,  tog_nxt;
  logic [DATA_W-1:0] res_r,  res_nxt;
  logic              fail_r, fail_nxt;
  logic              drop_r, drop_nxt;
  logic [CNT_W-1:0]  cnt_r,  cnt_nxt;
  logic              bc_start, bc_write, bc_done;
  logic [ADDR_W-1:0] bc_addr, poll_addr;
  logic [DATA_W-1:0] bc_wdata, bc_rdata;
  logic              erase_op, poll_op;
  pfc_bus_cycle u_cycle (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .start_i    (bc_start),
    .write_i    (bc_write),
    .addr_i     (bc_addr),
    .wdata_i    (bc_wdata),
    .done_o     (bc_done),
    .rdata_o    (bc_rdata),
    .fl_addr_o  (fl_addr_o),
    .fl_ce_n_o  (fl_ce_n_o),
    .fl_oe_n_o  (fl_oe_n_o),
    .fl_we_n_o  (fl_we_n_o),
    .fl_dq_o    (fl_dq_o),
    .fl_dq_oe_o (fl_dq_oe_o),
    .fl_dq_i    (fl_dq_i)
  );
  assign erase_op  = (op_r == PFC_OP_CHIP_ER) || (op_r == PFC_OP_SECT_ER) || (op_r == PFC_OP_RESUME);
  // Block erase returns after its confirm so the timeout stays open for added blocks
  assign poll_op   = (op_r == PFC_OP_CHIP_ER) || (op_r == PFC_OP_RESUME) || (op_r == PFC_OP_PROGRAM); // RULE10
  // Pause check polls outside the erased blocks
  assign poll_addr = (op_r == PFC_OP_PAUSE) ? {safe_addr_hi_i[2:0], a_r[BLK_LSB-1:0]} : a_r; // RULE20
  // Write sequence table per operation and step
  always_comb begin
    bc_write = 1'b1;
    bc_addr  = SETUP_ADDR;
    bc_wdata = UNLOCK1_DATA;
    if (rst_r) begin
      bc_wdata = CMD_RESET; // RULE24 RULE14
    end else if (op_r == PFC_OP_READ) begin
      bc_write = 1'b0; // RULE27
      bc_addr  = a_r;
    end else if (op_r == PFC_OP_PROT_RD && idx_r == 3'd3) begin
      bc_write = 1'b0;
      bc_addr  = {a_r[ADDR_W-1:BLK_LSB], PROT_ADDR[BLK_LSB-1:0]}; // RULE1 RULE2
    end else if (op_r == PFC_OP_ADD_BLK || op_r == PFC_OP_RESUME) begin
      bc_addr  = a_r;
      bc_wdata = CMD_SECT_ER; // RULE10 RULE22
    end else if (op_r == PFC_OP_PAUSE) begin
      bc_addr  = a_r;
      bc_wdata = CMD_PAUSE; // RULE18
    end else if (idx_r == 3'd0 || idx_r == 3'd3) begin
      bc_wdata = UNLOCK1_DATA; // RULE23
      if (idx_r == 3'd3 && op_r == PFC_OP_PROGRAM) begin
        bc_addr  = a_r;
        bc_wdata = d_r; // RULE15 RULE17
      end
    end else if (idx_r == 3'd1 || idx_r == 3'd4) begin
      bc_addr  = UNLOCK2_ADDR;
      bc_wdata = UNLOCK2_DATA; // RULE23
    end else if (idx_r == 3'd2) begin
      if (op_r == PFC_OP_PROGRAM) bc_wdata = CMD_PROGRAM;
      else if (op_r == PFC_OP_PROT_RD) bc_wdata = CMD_SIGNAT; // RULE25
      else bc_wdata = CMD_SETUP_ER; // RULE3 RULE9
    end else begin
      bc_addr  = (op_r == PFC_OP_SECT_ER) ? a_r : SETUP_ADDR;
      bc_wdata = (op_r == PFC_OP_SECT_ER) ? CMD_SECT_ER : CMD_CHIP_ER; // RULE3 RULE9 RULE5
    end
    if (st_r == PFC_POLL1 || st_r == PFC_POLL2) begin
      bc_write = 1'b0;
      bc_addr  = poll_addr;
    end
  end
  always_comb begin
    st_nxt   = st_r;
    idx_nxt  = idx_r;
    len_nxt  = len_r;
    op_nxt   = op_r;
    rst_nxt  = rst_r;
    a_nxt    = a_r;
    d_nxt    = d_r;
    tog_nxt  = tog_r;
    res_nxt  = res_r;
    fail_nxt = fail_r;
    drop_nxt = drop_r;
    cnt_nxt  = cnt_r;
    bc_start = 1'b0;
    done_o   = 1'b0;
    case (st_r)
      PFC_IDLE: begin
        if (req_i) begin
          st_nxt   = PFC_SEQ;
          idx_nxt  = 3'd0;
          op_nxt   = op_i;
          rst_nxt  = reset_cmd_i;
          a_nxt    = addr_i;
          d_nxt    = wdata_i;
          fail_nxt = 1'b0;
          drop_nxt = 1'b0;
          if (reset_cmd_i || op_i == PFC_OP_READ || op_i == PFC_OP_ADD_BLK
              || op_i == PFC_OP_PAUSE || op_i == PFC_OP_RESUME) len_nxt = 3'd0;
          else if (op_i == PFC_OP_PROGRAM || op_i == PFC_OP_PROT_RD) len_nxt = 3'd3;
          else len_nxt = 3'd5;
        end
      end
      PFC_SEQ: begin
        bc_start = 1'b1;
        st_nxt   = PFC_WAIT;
      end
      PFC_WAIT: begin
        if (bc_done) begin
          if (idx_r != len_r) begin
            idx_nxt = idx_r + 3'd1;
            st_nxt  = PFC_SEQ;
          end else if (rst_r && erase_op) begin
            cnt_nxt = CNT_W'(RST_WAIT_CYC); // RULE24
            st_nxt  = PFC_SUSPW;
          end else if (poll_op || op_r == PFC_OP_PAUSE) begin
            cnt_nxt = CNT_W'(SUSP_MAX_CYC); // RULE19
            st_nxt  = PFC_POLL1;
          end else begin
            res_nxt = bc_rdata;
            st_nxt  = PFC_FINISH;
          end
        end
      end
      PFC_POLL1: begin
        // Status reads follow the last write; toggle compared pairwise
        bc_start = (cnt_r != '0) || (op_r != PFC_OP_PAUSE);
        st_nxt   = bc_start ? PFC_POLL2 : PFC_FINISH; // RULE6
        // Only the first status read primes the toggle reference
        if (bc_start && idx_r != 3'd7) idx_nxt = 3'd6;
        if (cnt_r != '0) cnt_nxt = cnt_r - 1'b1;
      end
      PFC_POLL2: begin
        if (cnt_r != '0) cnt_nxt = cnt_r - 1'b1;
        if (bc_done) begin
          tog_nxt = bc_rdata;
          st_nxt  = PFC_POLL1;
          if (tog_r[ALT_BIT] == bc_rdata[ALT_BIT] && idx_r == 3'd7) begin // RULE8 RULE16 RULE19
            res_nxt = bc_rdata;
            st_nxt  = PFC_FINISH;
            if (op_r == PFC_OP_PROGRAM) drop_nxt = |(~d_r & bc_rdata); // RULE17
          end else if (tog_r[FAIL_BIT] && bc_rdata[FAIL_BIT] && idx_r == 3'd7) begin
            fail_nxt = 1'b1; // RULE8
            op_nxt   = PFC_OP_READ;
            rst_nxt  = 1'b1;
            idx_nxt  = 3'd0;
            len_nxt  = 3'd0;
            st_nxt   = PFC_ERRRST; // RULE14
          end
          idx_nxt = (st_nxt == PFC_ERRRST) ? 3'd0 : 3'd7;
        end
      end
      PFC_ERRRST: begin
        st_nxt = PFC_SEQ;
      end
      PFC_SUSPW: begin
        if (cnt_r == '0) st_nxt = PFC_FINISH;
        else cnt_nxt = cnt_r - 1'b1;
      end
      default: begin
        done_o = 1'b1;
        st_nxt = PFC_IDLE;
      end
    endcase
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r   <= PFC_IDLE; // RULE26
      idx_r  <= 3'd0;
      len_r  <= 3'd0;
      op_r   <= PFC_OP_READ;
      rst_r  <= 1'b0;
      a_r    <= '0;
      d_r    <= '0;
      tog_r  <= '0;
      res_r  <= '0;
      fail_r <= 1'b0;
      drop_r <= 1'b0;
      cnt_r  <= '0;
    end else begin
      st_r   <= st_nxt;
      idx_r  <= idx_nxt;
      len_r  <= len_nxt;
      op_r   <= op_nxt;
      rst_r  <= rst_nxt;
      a_r    <= a_nxt;
      d_r    <= d_nxt;
      tog_r  <= tog_nxt;
      res_r  <= res_nxt;
      fail_r <= fail_nxt;
      drop_r <= drop_nxt;
      cnt_r  <= cnt_nxt;
    end
  end
  // Block-erase accumulation: host must issue ADD_BLK within about 100us; RULE11 RULE12 RULE13
  assign ready_o        = (st_r == PFC_IDLE);
  assign rdata_o        = res_r;
  assign fail_o         = fail_r;
  assign bits_dropped_o = drop_r;
  // Limitation: RULE4 RULE7 RULE21 are kept by never issuing other commands mid-operation
  chk_we_not_oe: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !(!fl_we_n_o && !fl_oe_n_o)) else $error("write and read enables both low"); // RULE26
  chk_dq_drive_wr: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !fl_we_n_o |-> fl_dq_oe_o) else $error("data not driven during write"); // RULE15
  chk_unlock_second: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!fl_we_n_o && fl_addr_o == UNLOCK2_ADDR && fl_dq_o == UNLOCK2_DATA) |-> fl_ce_n_o == 1'b0)
    else $error("unlock write without chip enable"); // RULE23
  chk_done_pulse: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    done_o |=> !done_o) else $error("done held two cycles"); // RULE6
  chk_ready_idle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (req_i && ready_o) |=> !ready_o) else $error("request not taken"); // RULE3
  chk_reset_wait: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_r == PFC_SUSPW && cnt_r != '0) |=> !done_o) else $error("reset wait cut short"); // RULE24
  chk_pause_bound: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_r == PFC_POLL1 && op_r == PFC_OP_PAUSE && cnt_r == '0) |=> done_o)
    else $error("pause poll ran past limit"); // RULE19
  chk_fail_reset: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_r == PFC_ERRRST) |=> (st_r == PFC_SEQ && rst_r)) else $error("no reset after failure"); // RULE14
  cov_program: cover property (@(posedge mclk_i) disable iff (!rst_n_i) done_o && op_r == PFC_OP_PROGRAM);
  cov_sect_er: cover property (@(posedge mclk_i) disable iff (!rst_n_i) done_o && op_r == PFC_OP_SECT_ER);
  cov_pause:   cover property (@(posedge mclk_i) disable iff (!rst_n_i) done_o && op_r == PFC_OP_PAUSE);
endmodule : pfc_ctrl

// ===== verif/pfc_flash_model.sv
// Behavioural model of the byte-wide flash device on the far side.
// Assumes pins are sampled on mclk_i; timers count mclk_i cycles.
`timescale 1ns/10ps
module pfc_flash_model
  import pfc_pkg::*;
#(
  parameter int         PROG_CYC  = 200,
  parameter int         ACCUM_CYC = 10000,
  parameter int         ERASE_CYC = 3000,
  parameter int         SUSP_CYC  = 100,
  parameter logic [7:0] PROT_MASK = 8'h04,
  parameter logic [7:0] BAD_DATA  = 8'h3C,
  parameter logic [7:0] MAKER_ID  = 8'h5C  // Arbitrary value
) (
  input  wire logic              mclk_i,
  input  wire logic              fail_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              ce_n_i,
  input  wire logic              oe_n_i,
  input  wire logic              we_n_i,
  input  wire logic [DATA_W-1:0] dq_i,
  output logic      [DATA_W-1:0] dq_o
);
  typedef enum logic [2:0] {M_RD, M_SIG, M_PRG, M_ACC, M_ERS, M_PND, M_SUS} pfc_mode_e;
  pfc_mode_e   mode = M_RD;
  logic [7:0]  mem [int];
  logic [7:0]  blk  = 8'h00;
  logic [7:0]  rdv  = 8'h00;
  logic [7:0]  last = 8'h00;
  logic [7:0]  pd   = 8'h00;
  logic [7:0]  wd   = 8'h00;
  logic [18:0] wa   = 19'h00000;
  logic        chip = 1'b0;
  logic        tog  = 1'b0;
  logic        fl   = 1'b0;
  logic        we_q = 1'b1;
  logic        oe_q = 1'b1;
  int          step = 0;
  int          cnt  = 0;
  int          left = 0;

  function automatic logic [7:0] rmem(input logic [18:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
  endfunction : rmem

  function automatic logic [7:0] rval(input logic [18:0] a);
    case (mode)
      M_PRG:               return {~pd[7], tog, fl, 5'h00};
      M_ACC, M_ERS, M_PND: return {1'b0, tog, fl, 1'b0, mode != M_ACC, 3'h0};
      M_SIG:               return (a[0] | a[6] | !a[1]) ? MAKER_ID : {7'h00, PROT_MASK[a[18:16]]};
      M_SUS:               return blk[a[18:16]] ? BAD_DATA : rmem(a);
      default:             return rmem(a);
    endcase
  endfunction : rval

  task automatic to_read();
    mode = M_RD;
    step = 0;
    fl   = 1'b0;
    chip = 1'b0;
  endtask : to_read

  task automatic pend(input int rest);
    left = rest;
    mode = M_PND;
    cnt  = SUSP_CYC;
  endtask : pend

  task automatic seq(input logic [18:0] a, input logic [7:0] d);
    if (d == CMD_RESET) to_read();
    else case (step)
      0, 3: step = (a == UNLOCK1_ADDR && d == UNLOCK1_DATA) ? step + 1 : 0;
      1, 4: step = (a == UNLOCK2_ADDR && d == UNLOCK2_DATA) ? step + 1 : 0;
      2: begin
        step = (d == CMD_SETUP_ER && a == SETUP_ADDR) ? 3 : (d == CMD_PROGRAM) ? 6 : 0;
        if (d == CMD_SIGNAT && a == SETUP_ADDR) mode = M_SIG;
      end
      5: begin
        step = 0;
        if (d == CMD_CHIP_ER && a == SETUP_ADDR) begin
          chip = 1'b1;
          blk  = ~PROT_MASK;
          mode = M_ERS;
          cnt  = ERASE_CYC;
        end else if (d == CMD_SECT_ER) begin
          blk  = 8'h01 << a[18:16];
          mode = M_ACC;
          cnt  = ACCUM_CYC;
        end else mode = M_RD;
      end
      default: begin
        step = 0;
        if (!PROT_MASK[a[18:16]]) begin
          pd          = d;
          mem[int'(a)] = rmem(a) & d;
          mode        = M_PRG;
          cnt         = PROG_CYC;
        end
      end
    endcase
  endtask : seq

  task automatic wr_cmd(input logic [18:0] a, input logic [7:0] d);
    case (mode)
      M_PRG: ;
      M_ERS, M_PND: begin
        if (d == CMD_RESET) to_read();
        else if (d == CMD_PAUSE && !chip && mode == M_ERS) pend(cnt);
      end
      M_ACC: begin
        if (d == CMD_SECT_ER) begin
          blk[a[18:16]] = 1'b1;
          cnt           = ACCUM_CYC;
        end else if (d == CMD_PAUSE) pend(ERASE_CYC);
        else to_read();
      end
      M_SUS: begin
        if (d == CMD_SECT_ER) begin
          mode = M_ERS;
          cnt  = left;
        end else if (d == CMD_RESET) to_read();
      end
      default: seq(a, d);
    endcase
  endtask : wr_cmd

  task automatic erase_blocks();
    int q[$];
    foreach (mem[k]) if (blk[k[18:16]]) q.push_back(k);
    foreach (q[i]) mem.delete(q[i]);
  endtask : erase_blocks

  always @(posedge mclk_i) begin
    if (we_q && !we_n_i && !ce_n_i) wa = addr_i;
    if (!we_n_i && !ce_n_i) wd = dq_i;
    if (!we_q && we_n_i) wr_cmd(wa, wd);
    if (oe_q && !oe_n_i && !ce_n_i) tog = ~tog;
    we_q = we_n_i;
    oe_q = oe_n_i;
    if (cnt > 0) cnt = cnt - 1;
    else case (mode)
      M_PRG: mode = M_RD;
      M_ACC: begin
        mode = M_ERS;
        cnt  = ERASE_CYC;
      end
      M_ERS: begin
        if (fail_i) fl = 1'b1;
        else begin
          erase_blocks();
          to_read();
        end
      end
      M_PND: mode = M_SUS;
      default: ;
    endcase
    rdv = rval(addr_i);
    if (!ce_n_i && !oe_n_i) last = rdv;
  end
  // Released bus shows the inverse so a stale value cannot pass
  assign dq_o = (!ce_n_i && !oe_n_i) ? rdv : ~last;
endmodule : pfc_flash_model

// ===== verif/pfc_ctrl_tb_top.sv
// Self-checking bench for the flash host controller.
// Assumes the flash model on the pins; one request at a time.
`timescale 1ns/10ps
module pfc_ctrl_tb_top
  import pfc_pkg::*;
;
  localparam int          LIM = 60000;
  localparam logic [18:0] A1  = 19'h10123;
  localparam logic [18:0] A3  = 19'h30010;
  localparam logic [18:0] A5  = 19'h50020;
  logic              mclk_i         = 1'b0;
  logic              rst_n_i        = 1'b0;
  logic              req_i          = 1'b0;
  logic              reset_cmd_i    = 1'b0;
  logic              fail_inj       = 1'b0;
  logic [2:0]        op_i           = 3'h0;
  logic [ADDR_W-1:0] addr_i         = 19'h00000;
  logic [DATA_W-1:0] wdata_i        = 8'h00;
  logic [DATA_W-1:0] safe_addr_hi_i = 8'h00;
  logic              ready_o, done_o, fail_o, bits_dropped_o;
  logic              fl_ce_n_o, fl_oe_n_o, fl_we_n_o, fl_dq_oe_o;
  logic [DATA_W-1:0] rdata_o, fl_dq_o, fl_dq_i;
  logic [ADDR_W-1:0] fl_addr_o;
  int                error_cnt      = 0;
  int                checked        = 0;

  pfc_ctrl DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req_i), .op_i(op_i), .reset_cmd_i(reset_cmd_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .safe_addr_hi_i(safe_addr_hi_i), .ready_o(ready_o), .done_o(done_o),
    .rdata_o(rdata_o), .fail_o(fail_o), .bits_dropped_o(bits_dropped_o), .fl_addr_o(fl_addr_o),
    .fl_ce_n_o(fl_ce_n_o), .fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o), .fl_dq_o(fl_dq_o),
    .fl_dq_oe_o(fl_dq_oe_o), .fl_dq_i(fl_dq_i));
  pfc_flash_model u_flash (.mclk_i(mclk_i), .fail_i(fail_inj), .addr_i(fl_addr_o), .ce_n_i(fl_ce_n_o),
    .oe_n_i(fl_oe_n_o), .we_n_i(fl_we_n_o), .dq_i(fl_dq_o), .dq_o(fl_dq_i));

  initial forever #5 mclk_i = ~mclk_i;

  task automatic conclude();
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic do_op(input logic [2:0] op, input logic rc, input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge mclk_i);
    while (ready_o !== 1'b1 && n < LIM) begin
      @(negedge mclk_i);
      n++;
    end
    @(posedge mclk_i);
    req_i       <= 1'b1;
    op_i        <= op;
    reset_cmd_i <= rc;
    addr_i      <= a;
    wdata_i     <= d;
    @(posedge mclk_i);
    req_i       <= 1'b0;
    // Answer may take a whole erase, hence the wide bound
    do begin
      @(negedge mclk_i);
      n++;
    end while (done_o !== 1'b1 && n < LIM);
    if (n >= LIM) begin
      error_cnt++;
      $display("FAIL %0t no completion", $time);
      conclude();
    end
  endtask : do_op

  task automatic rd_until(input logic [18:0] a);
    int n;
    n = 0;
    do begin
      do_op(PFC_OP_READ, 1'b0, a, 8'h00);
      n++;
    end while (rdata_o !== 8'hFF && n < 2000);
    if (rdata_o !== 8'hFF) begin
      error_cnt++;
      $display("FAIL %0t read never settled", $time);
      conclude();
    end
  endtask : rd_until

  task automatic t_reset();
    @(negedge mclk_i);
    check({7'h00, ready_o}, 8'h01);
    check({7'h00, fl_we_n_o}, 8'h01);
  endtask : t_reset

  task automatic t_program();
    do_op(PFC_OP_PROGRAM, 1'b0, A1, 8'hA5);
    check({7'h00, bits_dropped_o}, 8'h00);
    do_op(PFC_OP_READ, 1'b0, A1, 8'h00);
    check(rdata_o, 8'hA5);
    do_op(PFC_OP_PROGRAM, 1'b0, A1, 8'h5A);
    do_op(PFC_OP_READ, 1'b0, A1, 8'h00);
    check(rdata_o, 8'h00);
    do_op(PFC_OP_PROGRAM, 1'b0, A3, 8'h00);
    do_op(PFC_OP_PROGRAM, 1'b0, A5, 8'h12);
    // Protected block ignores the program, so cleared bits stay set
    do_op(PFC_OP_PROGRAM, 1'b0, 19'h20010, 8'h00);
    check(rdata_o, 8'hFF);
    check({7'h00, bits_dropped_o}, 8'h01);
  endtask : t_program

  task automatic t_prot();
    do_op(PFC_OP_PROT_RD, 1'b0, 19'h20000, 8'h00);
    check(rdata_o, 8'h01);
    do_op(PFC_OP_PROT_RD, 1'b0, 19'h10000, 8'h00);
    check(rdata_o, 8'h00);
    do_op(PFC_OP_READ, 1'b1, 19'h00000, 8'h00);
    do_op(PFC_OP_READ, 1'b0, A1, 8'h00);
    check(rdata_o, 8'h00);
  endtask : t_prot

  task automatic t_erase();
    do_op(PFC_OP_SECT_ER, 1'b0, 19'h10000, 8'h00);
    do_op(PFC_OP_ADD_BLK, 1'b0, 19'h30000, 8'h00);
    do_op(PFC_OP_READ, 1'b0, A1, 8'h00);
    check({7'h00, rdata_o[ACCUM_BIT]}, 8'h00);
    check({7'h00, rdata_o[POLL_BIT]}, 8'h00);
    rd_until(A1);
    check(rdata_o, 8'hFF);
    do_op(PFC_OP_READ, 1'b0, A3, 8'h00);
    check(rdata_o, 8'hFF);
  endtask : t_erase

  task automatic t_pause();
    @(posedge mclk_i);
    safe_addr_hi_i <= 8'h01;
    do_op(PFC_OP_SECT_ER, 1'b0, 19'h50000, 8'h00);
    do_op(PFC_OP_PAUSE, 1'b0, 19'h00000, 8'h00);
    do_op(PFC_OP_READ, 1'b0, 19'h00100, 8'h00);
    check(rdata_o, 8'hFF);
    do_op(PFC_OP_READ, 1'b0, A5, 8'h00);
    check(rdata_o, 8'h3C);
    do_op(PFC_OP_RESUME, 1'b0, A5, 8'h00);
    rd_until(A5);
    check(rdata_o, 8'hFF);
  endtask : t_pause

  task automatic t_rst_wait();
    realtime t0;
    do_op(PFC_OP_SECT_ER, 1'b0, 19'h60000, 8'h00);
    t0 = $realtime;
    do_op(PFC_OP_SECT_ER, 1'b1, 19'h60000, 8'h00);
    check({7'h00, ($realtime - t0) > RST_WAIT_CYC * CLK_NS}, 8'h01);
    do_op(PFC_OP_READ, 1'b0, 19'h60000, 8'h00);
    check(rdata_o, 8'hFF);
  endtask : t_rst_wait

  task automatic t_chip_fail();
    fail_inj <= 1'b1;
    do_op(PFC_OP_CHIP_ER, 1'b0, 19'h00000, 8'h00);
    check({7'h00, fail_o}, 8'h01);
    fail_inj <= 1'b0;
    do_op(PFC_OP_READ, 1'b0, A1, 8'h00);
    check(rdata_o, 8'hFF);
  endtask : t_chip_fail

  initial begin
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_program();
    t_prot();
    t_erase();
    t_pause();
    t_rst_wait();
    t_chip_fail();
    conclude();
  end
endmodule : pfc_ctrl_tb_top
